// ==== src/blspc_pkg.sv ====
// Package: constants and carriers for the boot lock self-program control block
package blspc_pkg;
  localparam logic [7:0] ADDR_CSR      = 8'h00;
  localparam logic [7:0] ADDR_LOCK     = 8'h04;
  localparam logic [7:0] ADDR_FUSE     = 8'h08;
  localparam logic [7:0] ADDR_CPU      = 8'h0C;
  localparam logic [7:0] ADDR_STAT     = 8'h10;
  localparam int BIT_IRQ_EN   = 7;
  localparam int BIT_BUSY     = 6;
  localparam int BIT_REENABLE = 4;
  localparam int BIT_LOCKSET  = 3;
  localparam int BIT_PGWRITE  = 2;
  localparam int BIT_PGERASE  = 1;
  localparam int BIT_ENABLE   = 0;
  localparam logic [4:0] CMD_REENABLE = 5'h11;
  localparam logic [4:0] CMD_LOCKSET  = 5'h09;
  localparam logic [4:0] CMD_PGWRITE  = 5'h05;
  localparam logic [4:0] CMD_PGERASE  = 5'h03;
  localparam logic [4:0] CMD_LOAD     = 5'h01;
  localparam logic [7:0] CSR_RESET    = 8'h00;
  localparam logic [3:0] LOCK_RESET   = 4'hF;
  localparam logic [15:0] APP_RESET_VEC = 16'h0000;
  localparam logic [15:0] BOOT_START_DEF = 16'h1C00;
  localparam real CLK_MHZ = 200.0;
  localparam int ARM_CYCLES = 4;
  localparam int PROG_TIME_US = 4;
  localparam int PROG_CYCLES = int'(PROG_TIME_US * CLK_MHZ);
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    BLSPC_MODE1, BLSPC_MODE2, BLSPC_MODE3, BLSPC_MODE4
  } blspc_mode_e;
  typedef enum {BLSPC_IDLE, BLSPC_ARMED, BLSPC_PROG} blspc_state_e;
  typedef struct packed {
    logic        valid;
    logic        exec_in_boot;
    logic        target_boot;
    logic        target_rww;
  } blspc_instr_s;
endpackage

// ==== src/blspc_top.sv ====
// Module: self-program control register, boot lock and fuse access gating
`timescale 1ns/100ps
module blspc_top #(
  parameter int PROG_CNT = blspc_pkg::PROG_CYCLES
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire blspc_pkg::blspc_instr_s store_instr,
  input  wire blspc_pkg::blspc_instr_s load_instr,
  input  wire logic                  global_irq_flag,
  input  wire logic                  exec_in_boot,
  input  wire logic                  vectors_in_boot,
  input  wire logic                  prog_port_lock_wr,
  input  wire logic [3:0]            prog_port_lock_data,
  input  wire logic                  prog_port_fuse_wr,
  input  wire logic                  prog_port_fuse_data,
  input  wire logic                  chip_erase,
  output logic                       store_allowed,
  output logic                       load_allowed,
  output logic                       irq_mask,
  output logic                       store_ready_irq,
  output logic                       buffer_discard,
  output logic                       rww_blocked,
  output logic [15:0]                reset_vector
);
  logic        store_ready_irq_enable;
  logic        rewrite_section_busy;
  logic [4:0]  cmd;
  logic [2:0]  arm_cnt;
  logic [31:0] prog_cnt;
  logic        prog_active;
  logic        loading;
  logic [3:0]  lock_bits;
  logic        boot_reset_fuse;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [3:0]  refused_cnt;
  blspc_pkg::blspc_mode_e app_mode;
  blspc_pkg::blspc_mode_e boot_mode;
  logic        wr_fire;
  logic        csr_wr;
  logic        legal_pat;
  logic        store_go;
  logic        store_ok;
  logic        load_ok;
  logic [7:0]  csr_view;

  function automatic blspc_pkg::blspc_mode_e decode(input logic [1:0] f);
    case (f)
      2'b11:   decode = blspc_pkg::BLSPC_MODE1;
      2'b10:   decode = blspc_pkg::BLSPC_MODE2;
      2'b00:   decode = blspc_pkg::BLSPC_MODE3;
      default: decode = blspc_pkg::BLSPC_MODE4;
    endcase
  endfunction

  assign app_mode  = decode(lock_bits[1:0]);
  assign boot_mode = decode(lock_bits[3:2]);

  // Write channel: address and data may arrive in either order
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign csr_wr  = wr_fire && aw_addr == blspc_pkg::ADDR_CSR && w_strb[0];
  always_comb begin
    legal_pat = 1'b0;
    case (w_data[4:0])
      blspc_pkg::CMD_REENABLE, blspc_pkg::CMD_LOCKSET, blspc_pkg::CMD_PGWRITE,
      blspc_pkg::CMD_PGERASE, blspc_pkg::CMD_LOAD: legal_pat = 1'b1;
      default: legal_pat = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= blspc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Fuse and lock offsets are read-only from the processor side
        s_axi_bresp <= (aw_addr == blspc_pkg::ADDR_CSR) ? blspc_pkg::RESP_OKAY
                                                       : blspc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Command arming, four-cycle window
  assign store_go = store_instr.valid && cmd[blspc_pkg::BIT_ENABLE] && !prog_active;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd <= 5'h00;
      arm_cnt <= 3'h0;
      store_ready_irq_enable <= 1'b0;
    end else begin
      if (csr_wr) begin
        store_ready_irq_enable <= w_data[blspc_pkg::BIT_IRQ_EN];
      end
      // Programming in progress keeps store-enable high and refuses new patterns
      if (csr_wr && legal_pat && !prog_active && !cmd[blspc_pkg::BIT_ENABLE]) begin
        cmd <= w_data[4:0];
        arm_cnt <= 3'(blspc_pkg::ARM_CYCLES);
      end else if (store_go) begin
        if (cmd == blspc_pkg::CMD_PGERASE || cmd == blspc_pkg::CMD_PGWRITE) begin
          arm_cnt <= 3'h0;
        end else begin
          cmd <= 5'h00;
          arm_cnt <= 3'h0;
        end
      end else if (prog_active && prog_cnt == 32'h1) begin
        cmd <= 5'h00;
      end else if (!prog_active && arm_cnt != 3'h0) begin
        arm_cnt <= arm_cnt - 3'h1;
        if (arm_cnt == 3'h1) begin
          cmd <= 5'h00;
        end
      end
    end
  end

  // Erase or write timer and busy flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_active <= 1'b0;
      prog_cnt <= 32'h0;
      rewrite_section_busy <= 1'b0;
    end else begin
      if (store_go && store_ok &&
          (cmd == blspc_pkg::CMD_PGERASE || cmd == blspc_pkg::CMD_PGWRITE)) begin
        prog_active <= 1'b1;
        prog_cnt <= 32'(PROG_CNT);
        if (store_instr.target_rww) begin
          rewrite_section_busy <= 1'b1;
        end
      end else begin
        if (prog_active) begin
          prog_cnt <= prog_cnt - 32'h1;
          if (prog_cnt == 32'h1) begin
            prog_active <= 1'b0;
          end
        end
        if (store_go && (cmd == blspc_pkg::CMD_REENABLE || cmd == blspc_pkg::CMD_LOAD)) begin
          rewrite_section_busy <= 1'b0;
        end
      end
    end
  end

  // Page buffer loading and discard
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loading <= 1'b0;
      buffer_discard <= 1'b0;
    end else begin
      buffer_discard <= 1'b0;
      if (store_go && cmd == blspc_pkg::CMD_LOAD) begin
        loading <= 1'b1;
      end
      if (csr_wr && w_data[blspc_pkg::BIT_REENABLE] && loading) begin
        loading <= 1'b0;
        buffer_discard <= 1'b1;
      end else if (store_go && cmd == blspc_pkg::CMD_PGWRITE) begin
        loading <= 1'b0;
      end
    end
  end

  // Lock fields and fuse; lock mode of the general lock has no input here by design
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_bits <= blspc_pkg::LOCK_RESET;
      boot_reset_fuse <= 1'b1;
    end else begin
      if (chip_erase) begin
        lock_bits <= blspc_pkg::LOCK_RESET;
      end else if (prog_port_lock_wr) begin
        lock_bits <= lock_bits & prog_port_lock_data;
      end else if (store_go && cmd == blspc_pkg::CMD_LOCKSET) begin
        lock_bits <= lock_bits & w_data[11:8];
      end
      if (prog_port_fuse_wr) begin
        boot_reset_fuse <= prog_port_fuse_data;
      end
    end
  end

  // Access gating, independent of the general lock modes
  always_comb begin
    store_ok = 1'b1;
    if (store_instr.target_boot) begin
      if (boot_mode == blspc_pkg::BLSPC_MODE2 || boot_mode == blspc_pkg::BLSPC_MODE3) begin
        store_ok = 1'b0;
      end
    end else if (app_mode == blspc_pkg::BLSPC_MODE2 || app_mode == blspc_pkg::BLSPC_MODE3) begin
      store_ok = 1'b0;
    end
    load_ok = !(load_instr.target_rww && rewrite_section_busy);
    if (load_instr.exec_in_boot && !load_instr.target_boot &&
        (app_mode == blspc_pkg::BLSPC_MODE3 || app_mode == blspc_pkg::BLSPC_MODE4)) begin
      load_ok = 1'b0;
    end
    if (!load_instr.exec_in_boot && load_instr.target_boot &&
        (boot_mode == blspc_pkg::BLSPC_MODE3 || boot_mode == blspc_pkg::BLSPC_MODE4)) begin
      load_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_allowed <= 1'b0;
      load_allowed <= 1'b0;
      irq_mask <= 1'b0;
      store_ready_irq <= 1'b0;
      rww_blocked <= 1'b0;
      reset_vector <= blspc_pkg::APP_RESET_VEC;
    end else begin
      // Only the busy section is fenced off; the re-enable store itself must pass
      store_allowed <= store_instr.valid && store_ok &&
                       !(store_instr.target_rww && rewrite_section_busy);
      load_allowed <= load_instr.valid && load_ok;
      irq_mask <= (vectors_in_boot && !exec_in_boot &&
                   (app_mode == blspc_pkg::BLSPC_MODE3 ||
                    app_mode == blspc_pkg::BLSPC_MODE4)) ||
                  (!vectors_in_boot && exec_in_boot &&
                   (boot_mode == blspc_pkg::BLSPC_MODE3 ||
                    boot_mode == blspc_pkg::BLSPC_MODE4));
      store_ready_irq <= store_ready_irq_enable && global_irq_flag &&
                         !cmd[blspc_pkg::BIT_ENABLE];
      rww_blocked <= rewrite_section_busy;
      reset_vector <= boot_reset_fuse ? blspc_pkg::APP_RESET_VEC
                                      : blspc_pkg::BOOT_START_DEF;
    end
  end

  assign csr_view = {store_ready_irq_enable, rewrite_section_busy, 1'b0, cmd};

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= blspc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= blspc_pkg::RESP_OKAY;
        case (s_axi_araddr)
          blspc_pkg::ADDR_CSR:  s_axi_rdata <= {24'h000000, csr_view};
          blspc_pkg::ADDR_LOCK: s_axi_rdata <= {28'h0000000, lock_bits};
          blspc_pkg::ADDR_FUSE: s_axi_rdata <= {31'h0, boot_reset_fuse};
          blspc_pkg::ADDR_STAT: s_axi_rdata <= {28'h0000000, refused_cnt};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= blspc_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Saturating count of stores refused by the lock modes; stores blocked by the busy section are not counted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused_cnt <= 4'h0;
    end else if (store_instr.valid && !store_ok && refused_cnt != 4'hF) begin
      refused_cnt <= refused_cnt + 4'h1;
    end
  end

  // Arm window passes with no store instruction
  sequence arm_idle_s;
    $rose(cmd[blspc_pkg::BIT_ENABLE]) ##0 !store_instr.valid [*4];
  endsequence

  app_store_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    store_instr.valid && !store_instr.target_boot && !lock_bits[0] |=> !store_allowed)
    else $error("store into locked application section allowed");
  boot_store_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    store_instr.valid && store_instr.target_boot && !lock_bits[2] |=> !store_allowed)
    else $error("store into locked boot section allowed");
  arm_timeout_a: assert property (@(posedge aclk) disable iff (!aresetn)
    arm_idle_s |=> !cmd[blspc_pkg::BIT_ENABLE])
    else $error("store-enable outlived four cycles");
  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_rdata[5])
    else $error("reserved bit read nonzero");
  ready_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    store_ready_irq_enable && global_irq_flag && !cmd[0] |=> store_ready_irq)
    else $error("ready interrupt missing");
  illegal_pat_a: assert property (@(posedge aclk) disable iff (!aresetn)
    csr_wr && !legal_pat && !cmd[0] |=> cmd == 5'h00)
    else $error("illegal pattern took effect");
  busy_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rewrite_section_busy && load_instr.valid && load_instr.target_rww |=> !load_allowed)
    else $error("busy section was read");
  reset_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !boot_reset_fuse |=> reset_vector == blspc_pkg::BOOT_START_DEF)
    else $error("reset vector wrong");
  lock_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !chip_erase |=> (lock_bits & ~$past(lock_bits)) == 4'h0)
    else $error("lock bit unprogrammed without erase");
  prog_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    prog_active |-> cmd[blspc_pkg::BIT_ENABLE])
    else $error("store-enable dropped during programming");
  discard_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    csr_wr && w_data[blspc_pkg::BIT_REENABLE] && loading |=> buffer_discard)
    else $error("buffer not discarded on re-enable");
endmodule

// ==== test/blspc_cpu_model.sv ====
// Core model: issues store and load instructions on request
`timescale 1ns/100ps
module blspc_cpu_model (
  input  wire logic               aclk,
  input  wire logic               go_store,
  input  wire logic               go_load,
  input  wire logic [2:0]         go_attr,
  output blspc_pkg::blspc_instr_s store_instr,
  output blspc_pkg::blspc_instr_s load_instr
);
  logic       st_v = 1'b0;
  logic       ld_v = 1'b0;
  logic [2:0] attr = 3'h0;
  // One instruction per request, the edge after it, whether or not a command window is armed
  always @(posedge aclk) begin
    st_v <= go_store;
    ld_v <= go_load;
    attr <= go_attr;
  end
  // Idle fields show the inverse so that stale values never pass as real
  assign store_instr = {st_v, st_v ? attr : ~attr};
  assign load_instr  = {ld_v, ld_v ? attr : ~attr};
endmodule

// ==== test/testbench.sv ====
// Testbench: bus, lock, busy and fuse checks through the register bus and core model
`timescale 1ns/100ps
module testbench;
  localparam int PCNT = 24;
  localparam logic [7:0] CSR = blspc_pkg::ADDR_CSR;
  localparam logic [7:0] LOCK = blspc_pkg::ADDR_LOCK;
  localparam logic [7:0] FUSE = blspc_pkg::ADDR_FUSE;
  localparam logic [1:0] OK = blspc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = blspc_pkg::RESP_SLVERR;
  localparam logic [1:0] MCODE [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  // Response readies stay high; only one transfer is ever outstanding
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic gflag = 1'b0, exec_boot = 1'b0, vec_boot = 1'b0, chip_erase = 1'b0;
  logic lock_wr = 1'b0, fuse_wr = 1'b0, fuse_data = 1'b1;
  logic [3:0] lock_data = 4'hF;
  logic go_store = 1'b0, go_load = 1'b0;
  logic [2:0] go_attr = 3'h0;
  blspc_pkg::blspc_instr_s store_instr, load_instr;
  logic store_allowed, load_allowed, irq_mask, store_ready_irq, buffer_discard, rww_blocked;
  logic [15:0] reset_vector;
  logic [1:0] code;
  logic wp, rp;
  int err_total = 0, checks = 0, cyc = 0, discards = 0, n;

  blspc_cpu_model i_blspc_cpu_model (.aclk(aclk), .go_store(go_store), .go_load(go_load),
    .go_attr(go_attr), .store_instr(store_instr), .load_instr(load_instr));

  blspc_top #(.PROG_CNT(PCNT)) i_blspc_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .store_instr(store_instr), .load_instr(load_instr), .global_irq_flag(gflag),
    .exec_in_boot(exec_boot), .vectors_in_boot(vec_boot), .prog_port_lock_wr(lock_wr),
    .prog_port_lock_data(lock_data), .prog_port_fuse_wr(fuse_wr),
    .prog_port_fuse_data(fuse_data), .chip_erase(chip_erase), .store_allowed(store_allowed),
    .load_allowed(load_allowed), .irq_mask(irq_mask), .store_ready_irq(store_ready_irq),
    .buffer_discard(buffer_discard), .rww_blocked(rww_blocked), .reset_vector(reset_vector));

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cyc++;
    if (buffer_discard === 1'b1) discards++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(32'(bresp), 32'(er), "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata & m, ex, "read data");
    chk(32'(rresp), 32'(er), "read response");
  endtask

  // Attr is {exec_in_boot, target_boot, target_rww}; verdict lands two edges later
  task automatic ins(input logic st, input logic [2:0] at, input logic ex);
    go_store <= st;
    go_load <= !st;
    go_attr <= at;
    @(posedge aclk);
    go_store <= 1'b0;
    go_load <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(st ? store_allowed : load_allowed), 32'(ex), "instruction verdict");
  endtask

  // Store right after the command write, then let the arm window lapse
  task automatic arm(input logic [31:0] d, input logic [2:0] at, input logic ex);
    wr(CSR, d, OK);
    ins(1'b1, at, ex);
    repeat (6) @(posedge aclk);
  endtask

  task automatic prog(input logic e, input logic l, input logic [3:0] d);
    chip_erase <= e;
    lock_wr <= l;
    lock_data <= d;
    @(posedge aclk);
    chip_erase <= 1'b0;
    lock_wr <= 1'b0;
    @(posedge aclk);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CSR, 32'h0, 32'hFF, OK);
    rd(LOCK, 32'hF, 32'hF, OK);
    chk(32'(reset_vector), 32'(blspc_pkg::APP_RESET_VEC), "reset vector");
    rd(8'h0C, 32'h0, 32'hFFFFFFFF, ERR);
    wr(8'h0C, 32'h0, ERR);
    wr(FUSE, 32'h0, ERR);
    rd(FUSE, 32'h1, 32'h1, OK);
    wr(CSR, 32'h26, OK);
    rd(CSR, 32'h0, 32'h3F, OK);
    wr(CSR, 32'h1F, OK);
    rd(CSR, 32'h0, 32'h1F, OK);
    wr(CSR, 32'(blspc_pkg::CMD_LOAD), OK);
    repeat (8) @(posedge aclk);
    rd(CSR, 32'h0, 32'h1, OK);
    for (int m = 0; m < 4; m++) begin
      code = MCODE[m];
      wp = (m == 1 || m == 2);
      rp = (m >= 2);
      prog(1'b1, 1'b0, 4'hF);
      prog(1'b0, 1'b1, {code, code});
      rd(LOCK, 32'({code, code}), 32'hF, OK);
      arm(32'(blspc_pkg::CMD_LOAD), 3'h4, !wp);
      arm(32'(blspc_pkg::CMD_LOAD), 3'h6, !wp);
      ins(1'b0, 3'h4, !rp);
      ins(1'b0, 3'h2, !rp);
      vec_boot <= 1'b1;
      exec_boot <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(32'(irq_mask), 32'(rp), "mask in application code");
      vec_boot <= 1'b0;
      exec_boot <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(32'(irq_mask), 32'(rp), "mask in boot code");
    end
    prog(1'b1, 1'b0, 4'hF);
    arm(32'h0C09, 3'h6, 1'b1);
    rd(LOCK, 32'hC, 32'hF, OK);
    ins(1'b1, 3'h4, 1'b0);
    ins(1'b0, 3'h4, 1'b0);
    ins(1'b0, 3'h2, 1'b1);
    chk(32'(irq_mask), 32'h0, "mask follows boot field");
    prog(1'b0, 1'b1, 4'hF);
    rd(LOCK, 32'hC, 32'hF, OK);
    prog(1'b1, 1'b0, 4'hF);
    rd(LOCK, 32'hF, 32'hF, OK);
    gflag <= 1'b1;
    wr(CSR, 32'h83, OK);
    ins(1'b1, 3'h5, 1'b1);
    rd(CSR, 32'h41, 32'h41, OK);
    chk(32'(rww_blocked), 32'h1, "busy copy");
    chk(32'(store_ready_irq), 32'h0, "ready irq while armed");
    ins(1'b0, 3'h5, 1'b0);
    ins(1'b1, 3'h5, 1'b0);
    wr(CSR, 32'h91, OK);
    rd(CSR, 32'h03, 32'h1F, OK);
    repeat (30) @(posedge aclk);
    rd(CSR, 32'h40, 32'h41, OK);
    chk(32'(store_ready_irq), 32'h1, "ready irq when idle");
    gflag <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(store_ready_irq), 32'h0, "ready irq global off");
    arm(32'(blspc_pkg::CMD_REENABLE), 3'h6, 1'b1);
    rd(CSR, 32'h0, 32'h41, OK);
    chk(32'(rww_blocked), 32'h0, "busy copy cleared");
    arm(32'(blspc_pkg::CMD_PGWRITE), 3'h5, 1'b1);
    rd(CSR, 32'h40, 32'h40, OK);
    repeat (30) @(posedge aclk);
    arm(32'(blspc_pkg::CMD_LOAD), 3'h6, 1'b1);
    rd(CSR, 32'h0, 32'h40, OK);
    n = discards;
    arm(32'(blspc_pkg::CMD_REENABLE), 3'h6, 1'b1);
    chk(32'(discards - n), 32'h1, "buffer discard");
    rd(blspc_pkg::ADDR_STAT, 32'h5, 32'hF, OK);
    fuse_data <= 1'b0;
    fuse_wr <= 1'b1;
    @(posedge aclk);
    fuse_wr <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'(reset_vector), 32'(blspc_pkg::BOOT_START_DEF), "boot vector");
    rd(FUSE, 32'h0, 32'h1, OK);
    conclude();
  end
endmodule
